// >>> core/disk_status_pkg.sv
// Purpose: Shared constants for the disk sector transfer and status block
// Assumes: 250 MHz system clock, 8-bit I/O port bus with four port locations
// Notes: Port indices are offsets from the board base address

package disk_status_pkg;

  // I/O port locations (read side)
  localparam logic [1:0] PORT_STATUS = 2'h0;
  localparam logic [1:0] PORT_SECONDARY = 2'h1;
  localparam logic [1:0] PORT_SEEK_ACK = 2'h2;
  localparam logic [1:0] PORT_DATA = 2'h3;
  // I/O port locations (write side)
  localparam logic [1:0] PORT_COMMAND = 2'h1;
  localparam logic [1:0] PORT_DRIVE_SEL = 2'h2;

  // Command codes on the command port
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;

  // Primary status bit positions
  localparam int BIT_IDLE = 7;
  localparam int BIT_INDEX = 6;
  localparam int BIT_READY = 5;
  localparam int BIT_FAULT = 4;
  localparam int BIT_TRACK0 = 3;
  localparam int BIT_XFER_DONE = 2;
  localparam int BIT_SEEKS_IDLE = 1;
  localparam int BIT_TIMEOUT = 0;
  // Secondary status bit positions
  localparam int BIT_SEEK_DONE = 0;
  localparam int BIT_CRC_FAIL = 1;

  // Drive pin vector positions
  localparam int PIN_INDEX = 0;
  localparam int PIN_READY = 1;
  localparam int PIN_FAULT_N = 2;
  localparam int PIN_SEEKS_IDLE = 3;
  localparam int PIN_TRACK0 = 4;
  localparam int PIN_RBIT = 5;
  localparam int PIN_RSTROBE = 6;
  localparam int NUM_PINS = 7;

  // Sector geometry and timeout
  localparam int SECTOR_BYTES = 512;
  localparam int DATA_BITS = SECTOR_BYTES * 8;
  localparam int CRC_BITS = 16;
  localparam int TOTAL_BITS = DATA_BITS + CRC_BITS;
  localparam int TIMEOUT_REVS = 8;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // Write bit cell timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_PERIOD_NS = 100;
  localparam int BIT_CYCLES = (BIT_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 : (BIT_PERIOD_NS / CLK_PERIOD_NS);

  // Reset values
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [1:0] DRIVE_RESET = 2'h0;

  typedef enum {XFER_IDLE, XFER_READ, XFER_CHECK, XFER_WRITE} xfer_state_t;

endpackage : disk_status_pkg

// >>> core/sector_byte_fifo.sv
// Purpose: Small byte FIFO between the serial engine and the sector buffer
// Assumes: Single clock, synchronous active-low reset
// Notes: Flush empties it in one cycle; push and pop may coincide

module sector_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  // Full and empty from the count
  assign in_ready_out = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and count update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush_in) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push) next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      if (pop) next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      if (push && !pop) next_count = CW'(count + 1'b1);
      if (pop && !push) next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset, the count guards it
  always_ff @(posedge clk_in) begin
    if (push && !flush_in) mem[wr_ptr] <= in_data_in;
  end

endmodule : sector_byte_fifo

// >>> core/serial_crc16.sv
// Purpose: Serial 16th-order polynomial divider for sector CRC
// Assumes: One bit per feed pulse, most significant bit first
// Notes: Feeding the remainder back in leaves a zero residue

module serial_crc16
  import disk_status_pkg::*;
#(
  parameter logic [15:0] POLY = CRC_POLY,
  parameter logic [15:0] INIT = CRC_INIT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic clear_in,
  input wire logic feed_in,
  input wire logic bit_in,
  // Remainder
  output logic [15:0] crc_out
);

  logic [15:0] crc, next_crc;
  logic feedback;

  // One division step per fed bit
  always_comb begin
    feedback = crc[15] ^ bit_in;
    next_crc = crc;
    if (clear_in) next_crc = INIT;
    else if (feed_in) next_crc = {crc[14:0], 1'b0} ^ (feedback ? POLY : 16'h0000);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) crc <= INIT;
    else crc <= next_crc;
  end

  assign crc_out = crc;

endmodule : serial_crc16

// >>> core/disk_sector_transfer_status.sv
// Purpose: Status, timeout and CRC logic of a sector transfer disk controller
// Assumes: Only the selected drive drives the pins
// Notes: Host reaches four I/O port locations; buffer holds one sector

module disk_sector_transfer_status
  import disk_status_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int BIT_CELL_CYCLES = BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host I/O ports
  input wire logic [1:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  // Drive status pins
  input wire logic index_pulse_in,
  input wire logic drive_ready_in,
  input wire logic write_fault_n_in,
  input wire logic all_seeks_idle_in,
  input wire logic track0_in,
  // Drive read stream
  input wire logic read_bit_in,
  input wire logic read_strobe_in,
  // Drive control pins
  output logic [1:0] drive_select_out,
  output logic read_gate_out,
  output logic write_gate_out,
  output logic write_bit_out,
  output logic write_strobe_out
);

  localparam int BW = 13;
  localparam int TW = $clog2(BIT_CELL_CYCLES + 1);

  xfer_state_t state, next_state;
  logic [7:0] buffer_mem [SECTOR_BYTES];
  logic [NUM_PINS-1:0] pins, sync1, sync2, sync3, level, next_level, level_prev;
  logic [1:0] drive_sel, next_drive_sel;
  logic [3:0] drive_seen, next_drive_seen;
  logic timeout_flag, next_timeout_flag, crc_fail_flag, next_crc_fail_flag;
  logic seek_fin_flag, next_seek_fin_flag, xfer_fin_flag, next_xfer_fin_flag;
  logic fault_flag, next_fault_flag, fault_pend, next_fault_pend;
  logic index_level, next_index_level;
  logic [3:0] rev_cnt, next_rev_cnt;
  logic [BW-1:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [3:0] shift_cnt, next_shift_cnt;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic [8:0] host_ptr, next_host_ptr;
  logic [9:0] xfer_ptr, next_xfer_ptr;
  logic [7:0] rdata, next_rdata;
  logic wbit, next_wbit, wstrobe, next_wstrobe;
  logic push_valid, next_push_valid;
  logic [7:0] push_data, next_push_data;
  logic idx_rise, seeks_rise, rbit_evt, cmd_wr, busy;
  logic crc_clear, crc_feed, crc_bit;
  logic [15:0] crc_val;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
  logic [7:0] fifo_in_data, fifo_out_data;
  logic mem_we;
  logic [8:0] mem_waddr;
  logic [7:0] mem_wdata;

  assign pins = {read_strobe_in, read_bit_in, track0_in, all_seeks_idle_in,
                 write_fault_n_in, drive_ready_in, index_pulse_in};

  // Three-flop pin syncs; stages two and three must agree
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      always_comb begin
        next_level[g] = (sync2[g] == sync3[g]) ? sync3[g] : level[g];
      end
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          level[g] <= 1'b0;
          level_prev[g] <= 1'b0;
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          level[g] <= next_level[g];
          level_prev[g] <= level[g];
        end
      end
    end
  endgenerate

  // Edge events from the filtered levels
  assign idx_rise = level[PIN_INDEX] && !level_prev[PIN_INDEX];
  assign seeks_rise = level[PIN_SEEKS_IDLE] && !level_prev[PIN_SEEKS_IDLE];
  assign rbit_evt = level[PIN_RSTROBE] && !level_prev[PIN_RSTROBE];
  assign cmd_wr = io_wr_in && (io_addr_in == PORT_COMMAND);
  assign busy = (state != XFER_IDLE);

  // Gates follow the transfer state
  assign read_gate_out = (state == XFER_READ);
  assign write_gate_out = (state == XFER_WRITE);
  assign drive_select_out = drive_sel;
  assign io_rdata_out = rdata;
  assign write_bit_out = wbit;
  assign write_strobe_out = wstrobe;

  // FIFO sources: read assembler or sector buffer; sinks: buffer or serialiser
  always_comb begin
    fifo_in_valid = (state == XFER_READ) ? push_valid
                  : ((state == XFER_WRITE) && (xfer_ptr < 10'(SECTOR_BYTES)));
    fifo_in_data = (state == XFER_READ) ? push_data : buffer_mem[xfer_ptr[8:0]];
    fifo_out_ready = (state == XFER_READ) || (state == XFER_CHECK)
                   || ((state == XFER_WRITE) && (shift_cnt == 4'h0) && (bit_cnt < BW'(DATA_BITS)));
  end

  sector_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  serial_crc16 u_crc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(crc_clear),
    .feed_in(crc_feed),
    .bit_in(crc_bit),
    .crc_out(crc_val)
  );

  // Next values of state, flags, counters and host port
  always_comb begin
    next_state = state;
    next_drive_sel = drive_sel;
    next_drive_seen = drive_seen;
    next_timeout_flag = timeout_flag;
    next_crc_fail_flag = crc_fail_flag;
    next_seek_fin_flag = seek_fin_flag;
    next_xfer_fin_flag = xfer_fin_flag;
    next_fault_flag = fault_flag;
    next_fault_pend = fault_pend;
    next_index_level = index_level;
    next_rev_cnt = rev_cnt;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_shift_cnt = shift_cnt;
    next_tick_cnt = tick_cnt;
    next_host_ptr = host_ptr;
    next_xfer_ptr = xfer_ptr;
    next_rdata = rdata;
    next_wbit = wbit;
    next_wstrobe = 1'b0;
    next_push_valid = 1'b0;
    next_push_data = push_data;
    crc_clear = 1'b0;
    crc_feed = 1'b0;
    crc_bit = 1'b0;
    fifo_flush = 1'b0;
    mem_we = 1'b0;
    mem_waddr = host_ptr;
    mem_wdata = io_wdata_in;

    if (idx_rise) next_index_level = !index_level;

    // seek finished event; the set wins over the read clear
    if (seeks_rise) next_seek_fin_flag = 1'b1;
    else if (io_rd_in && (io_addr_in == PORT_SEEK_ACK)) next_seek_fin_flag = 1'b0;

    // two low bits pick the drive
    if (io_wr_in && (io_addr_in == PORT_DRIVE_SEL)) begin
      next_drive_sel = io_wdata_in[1:0];
      if (!drive_seen[io_wdata_in[1:0]]) begin
        next_drive_seen[io_wdata_in[1:0]] = 1'b1;
        next_fault_flag = 1'b0;
      end
    end

    // fault watch while write gate is active
    if (state == XFER_WRITE && (!level[PIN_FAULT_N] || read_gate_out)) next_fault_pend = 1'b1;

    // Host status reads are registered; buffer only reachable while idle
    if (io_rd_in) begin
      case (io_addr_in)
        PORT_STATUS: begin
          next_rdata = {!busy, index_level, level[PIN_READY], fault_flag, level[PIN_TRACK0],
                        xfer_fin_flag, level[PIN_SEEKS_IDLE], timeout_flag};
        end
        PORT_SECONDARY: begin
          next_rdata = 8'h00;
          next_rdata[BIT_SEEK_DONE] = seek_fin_flag;
          next_rdata[BIT_CRC_FAIL] = crc_fail_flag;
        end
        PORT_DATA: begin
          next_rdata = busy ? 8'h00 : buffer_mem[host_ptr];
          if (!busy) next_host_ptr = 9'(host_ptr + 1'b1);
        end
        default: next_rdata = 8'h00;
      endcase
    end

    // host fills the buffer while idle
    if (io_wr_in && (io_addr_in == PORT_DATA) && !busy) begin
      mem_we = 1'b1;
      next_host_ptr = 9'(host_ptr + 1'b1);
    end

    case (state)
      XFER_IDLE: begin
        if (cmd_wr) begin
          next_xfer_fin_flag = 1'b0;
          next_host_ptr = 9'h000;
          if (io_wdata_in == CMD_READ || io_wdata_in == CMD_WRITE) begin
            next_state = (io_wdata_in == CMD_READ) ? XFER_READ : XFER_WRITE;
            next_timeout_flag = 1'b0;
            next_rev_cnt = 4'h0;
            next_bit_cnt = '0;
            next_xfer_ptr = 10'h000;
            next_shift_cnt = 4'h0;
            next_tick_cnt = '0;
            next_fault_pend = 1'b0;
            fifo_flush = 1'b1;
            crc_clear = 1'b1;
          end
        end
      end
      XFER_READ: begin
        // every arriving bit, data and remainder, enters the divider
        if (rbit_evt) begin
          crc_feed = 1'b1;
          crc_bit = level[PIN_RBIT];
          next_bit_cnt = BW'(bit_cnt + 1'b1);
          if (bit_cnt < BW'(DATA_BITS)) begin
            next_shift = {shift[6:0], level[PIN_RBIT]};
            if (bit_cnt[2:0] == 3'h7) begin
              next_push_valid = 1'b1;
              next_push_data = {shift[6:0], level[PIN_RBIT]};
            end
          end
          if (bit_cnt == BW'(TOTAL_BITS - 1)) next_state = XFER_CHECK;
        end
      end
      XFER_CHECK: begin
        // remainder judged once the buffer has caught up
        if (!fifo_out_valid && !push_valid) begin
          next_state = XFER_IDLE;
          next_xfer_fin_flag = 1'b1;
          // cleared by a zero remainder here or by any completed write
          next_crc_fail_flag = (crc_val != 16'h0000);
        end
      end
      XFER_WRITE: begin
        // Serialiser stalls on an empty shift register, so the FIFO can fill
        if (shift_cnt == 4'h0 && fifo_out_valid && bit_cnt < BW'(DATA_BITS)) begin
          next_shift = fifo_out_data;
          next_shift_cnt = 4'h8;
        end
        if (tick_cnt != '0) begin
          next_tick_cnt = TW'(tick_cnt - 1'b1);
        end else if (bit_cnt < BW'(DATA_BITS)) begin
          if (shift_cnt != 4'h0) begin
            crc_feed = 1'b1;
            crc_bit = shift[7];
            next_wbit = shift[7];
            next_wstrobe = 1'b1;
            next_shift = {shift[6:0], 1'b0};
            next_shift_cnt = 4'(shift_cnt - 1'b1);
            next_bit_cnt = BW'(bit_cnt + 1'b1);
            next_tick_cnt = TW'(BIT_CELL_CYCLES - 1);
          end
        end else if (bit_cnt < BW'(TOTAL_BITS)) begin
          crc_feed = 1'b1;
          crc_bit = crc_val[15];
          next_wbit = crc_val[15];
          next_wstrobe = 1'b1;
          next_bit_cnt = BW'(bit_cnt + 1'b1);
          next_tick_cnt = TW'(BIT_CELL_CYCLES - 1);
        end else begin
          next_state = XFER_IDLE;
          next_xfer_fin_flag = 1'b1;
          next_crc_fail_flag = 1'b0;
          // fault reflects the gate period just ended
          next_fault_flag = fault_pend || !level[PIN_FAULT_N];
        end
      end
      default: next_state = XFER_IDLE;
    endcase

    if (busy && idx_rise) begin
      next_rev_cnt = 4'(rev_cnt + 1'b1);
      if (rev_cnt == 4'(TIMEOUT_REVS - 1)) begin
        next_state = XFER_IDLE;
        next_timeout_flag = 1'b1;
        next_xfer_fin_flag = 1'b1;
        // timeout also counts as CRC failure
        next_crc_fail_flag = 1'b1;
        if (state == XFER_WRITE) next_fault_flag = fault_pend;
      end
    end

    // drained bytes land in the sector buffer
    if ((state == XFER_READ || state == XFER_CHECK) && fifo_out_valid) begin
      mem_we = 1'b1;
      mem_waddr = xfer_ptr[8:0];
      mem_wdata = fifo_out_data;
      next_xfer_ptr = 10'(xfer_ptr + 1'b1);
    end else if (state == XFER_WRITE && fifo_in_valid && fifo_in_ready) begin
      next_xfer_ptr = 10'(xfer_ptr + 1'b1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= XFER_IDLE;
      drive_sel <= DRIVE_RESET;
      drive_seen <= 4'h0;
      timeout_flag <= FLAG_RESET;
      crc_fail_flag <= FLAG_RESET;
      seek_fin_flag <= FLAG_RESET;
      xfer_fin_flag <= FLAG_RESET;
      fault_flag <= FLAG_RESET;
      fault_pend <= FLAG_RESET;
      index_level <= 1'b0;
      rev_cnt <= 4'h0;
      bit_cnt <= '0;
      shift <= 8'h00;
      shift_cnt <= 4'h0;
      tick_cnt <= '0;
      host_ptr <= 9'h000;
      xfer_ptr <= 10'h000;
      rdata <= 8'h00;
      wbit <= 1'b0;
      wstrobe <= 1'b0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else begin
      state <= next_state;
      drive_sel <= next_drive_sel;
      drive_seen <= next_drive_seen;
      timeout_flag <= next_timeout_flag;
      crc_fail_flag <= next_crc_fail_flag;
      seek_fin_flag <= next_seek_fin_flag;
      xfer_fin_flag <= next_xfer_fin_flag;
      fault_flag <= next_fault_flag;
      fault_pend <= next_fault_pend;
      index_level <= next_index_level;
      rev_cnt <= next_rev_cnt;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      shift_cnt <= next_shift_cnt;
      tick_cnt <= next_tick_cnt;
      host_ptr <= next_host_ptr;
      xfer_ptr <= next_xfer_ptr;
      rdata <= next_rdata;
      wbit <= next_wbit;
      wstrobe <= next_wstrobe;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
    end
  end

  // Sector buffer; data only, so no reset
  always_ff @(posedge clk_in) begin
    if (mem_we) buffer_mem[mem_waddr] <= mem_wdata;
  end

endmodule : disk_sector_transfer_status

// >>> verif/disk_drive_model.sv
// Purpose: Drive model, read stream and write capture
// Assumes: Strobe held 5 cycles for the pin syncs
// Notes: Idle data line toggles, strobe rests
module disk_drive_model
  import disk_status_pkg::*;
(
  // Clock and gates
  input wire logic clk_in,
  input wire logic read_gate_in,
  input wire logic write_gate_in,
  input wire logic write_bit_in,
  input wire logic write_strobe_in,
  // Scenario controls
  input wire logic mute_in,
  input wire logic bad_crc_in,
  // Read stream and write capture
  output logic read_bit_out,
  output logic read_strobe_out,
  output logic [15:0] wr_bits_out,
  output logic [15:0] wr_rem_out,
  output logic [7:0] wr_head_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] crc;
  logic [7:0] d;
  logic b;
  logic gate_q = 1'b0;
  function automatic logic [15:0] step(input logic [15:0] c, input logic x);
    return {c[14:0], 1'b0} ^ ((c[15] ^ x) ? CRC_POLY : 16'h0000);
  endfunction : step
  // Read frame: data, then remainder
  initial begin
    read_bit_out = 1'b0;
    read_strobe_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (read_gate_in && !mute_in) begin
        crc = CRC_INIT;
        for (int i = 0; i < TOTAL_BITS; i++) begin
          d = 8'(i / 8) ^ 8'h5a;
          b = (i < DATA_BITS) ? d[7 - i % 8] : crc[TOTAL_BITS - 1 - i] ^ (bad_crc_in && i == TOTAL_BITS - 1);
          if (i < DATA_BITS) crc = step(crc, b);
          read_bit_out <= b;
          repeat (5) @(posedge clk_in);
          read_strobe_out <= 1'b1;
          repeat (5) @(posedge clk_in);
          read_strobe_out <= 1'b0;
        end
        while (read_gate_in) @(posedge clk_in);
      end else begin
        read_bit_out <= ~read_bit_out;
      end
    end
  end
  // Write capture: residue must end at zero
  always @(posedge clk_in) begin
    gate_q <= write_gate_in;
    if (write_gate_in && !gate_q) begin
      wr_bits_out <= 16'h0000;
      wr_rem_out <= CRC_INIT;
    end else if (write_gate_in && write_strobe_in) begin
      wr_bits_out <= wr_bits_out + 16'h0001;
      wr_rem_out <= step(wr_rem_out, write_bit_in);
      if (wr_bits_out < 16'h0008) wr_head_out <= {wr_head_out[6:0], write_bit_in};
    end
  end
endmodule : disk_drive_model

// >>> verif/disk_sector_transfer_status_properties.sv
// Purpose: Port-level assertions
// Assumes: One clock, synchronous active-low reset
// Notes: Bound below
module disk_sector_transfer_status_properties
  import disk_status_pkg::*;
(
  // Clock, reset and host port
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [7:0] io_rdata_out,
  // Drive control
  input wire logic [1:0] drive_select_out,
  input wire logic read_gate_out,
  input wire logic write_gate_out,
  input wire logic write_strobe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_ack; io_rd_in && io_addr_in == PORT_SEEK_ACK |=> io_rdata_out == 8'h00; endproperty
  a_ack: assert property (p_ack) else $error("seek ack read not zero");
  property p_sec; io_rd_in && io_addr_in == PORT_SECONDARY |=> io_rdata_out[7:2] == 6'h00; endproperty
  a_sec: assert property (p_sec) else $error("secondary upper bits set");
  property p_gates; !(read_gate_out && write_gate_out); endproperty
  a_gates: assert property (p_gates) else $error("both gates active");
  property p_wstb; write_strobe_out |-> write_gate_out ##1 !write_strobe_out; endproperty
  a_wstb: assert property (p_wstb) else $error("write strobe outside gate");
  property p_sel; io_wr_in && io_addr_in == PORT_DRIVE_SEL |=> drive_select_out == $past(io_wdata_in[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("drive select mismatch");
  property p_wgo; $rose(write_gate_out) |-> $past(io_wr_in && io_addr_in == PORT_COMMAND && io_wdata_in == CMD_WRITE); endproperty
  a_wgo: assert property (p_wgo) else $error("write gate without command");
  property p_rgo; $rose(read_gate_out) |-> $past(io_wr_in && io_addr_in == PORT_COMMAND && io_wdata_in == CMD_READ); endproperty
  a_rgo: assert property (p_rgo) else $error("read gate without command");
  property p_rst; $rose(rst_n_in) |-> !read_gate_out && !write_gate_out && drive_select_out == DRIVE_RESET; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : disk_sector_transfer_status_properties
bind disk_sector_transfer_status disk_sector_transfer_status_properties i_props (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
  .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .drive_select_out(drive_select_out),
  .read_gate_out(read_gate_out), .write_gate_out(write_gate_out), .write_strobe_out(write_strobe_out));

// >>> verif/disk_sector_transfer_status_tb.sv
// Purpose: Self-checking bench
// Assumes: Two-cycle bit cell
// Notes: One long read frame
module disk_sector_transfer_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import disk_status_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, io_rd_in = 1'b0, io_wr_in = 1'b0, mute = 1'b0, bad_crc = 1'b0;
  logic index_pulse_in = 1'b0, drive_ready_in = 1'b1, write_fault_n_in = 1'b0, all_seeks_idle_in = 1'b0;
  logic [1:0] io_addr_in = 2'h0, drive_select_out;
  logic [7:0] io_wdata_in = 8'h00, io_rdata_out, wr_head;
  logic read_gate_out, write_gate_out, write_bit_out, write_strobe_out, read_bit, read_strobe;
  logic [15:0] wr_bits, wr_rem;
  int mismatches = 0, samples_checked = 0;
  always #2 clk_in = ~clk_in;
  disk_sector_transfer_status #(.BIT_CELL_CYCLES(2)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out), .index_pulse_in(index_pulse_in), .drive_ready_in(drive_ready_in),
    .write_fault_n_in(write_fault_n_in), .all_seeks_idle_in(all_seeks_idle_in), .track0_in(1'b0),
    .read_bit_in(read_bit), .read_strobe_in(read_strobe), .drive_select_out(drive_select_out),
    .read_gate_out(read_gate_out), .write_gate_out(write_gate_out), .write_bit_out(write_bit_out),
    .write_strobe_out(write_strobe_out));
  disk_drive_model i_drive (.clk_in(clk_in), .read_gate_in(read_gate_out), .write_gate_in(write_gate_out),
    .write_bit_in(write_bit_out), .write_strobe_in(write_strobe_out), .mute_in(mute), .bad_crc_in(bad_crc),
    .read_bit_out(read_bit), .read_strobe_out(read_strobe), .wr_bits_out(wr_bits), .wr_rem_out(wr_rem),
    .wr_head_out(wr_head));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobes; read data a cycle later
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    io_addr_in <= a;
    io_wdata_in <= v;
    io_wr_in <= 1'b1;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge clk_in);
    io_rd_in <= 1'b0;
    #1 v = io_rdata_out;
  endtask : rd
  // Let pins pass the syncs first
  task automatic st(input int b, input logic e, input logic [1:0] a = PORT_STATUS);
    logic [7:0] v;
    repeat (6) @(posedge clk_in);
    rd(a, v);
    chk(v[b], e);
  endtask : st
  task automatic wait_idle();
    logic [7:0] v = 8'h00;
    for (int n = 0; n < 50000 && v[BIT_IDLE] !== 1'b1; n++)
      rd(PORT_STATUS, v);
    chk(v[BIT_IDLE], 1'b1);
  endtask : wait_idle
  task automatic pulse(input int n);
    repeat (n) begin
      index_pulse_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      index_pulse_in <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
  endtask : pulse
  task automatic t_reset();
    st(BIT_IDLE, 1'b1);
    st(BIT_TIMEOUT, 1'b0);
    st(BIT_XFER_DONE, 1'b0);
    st(BIT_CRC_FAIL, 1'b0, PORT_SECONDARY);
  endtask : t_reset
  task automatic t_pins();
    logic [7:0] v;
    wr(PORT_DRIVE_SEL, 8'hfe);
    #1;
    chk(drive_select_out, 2'h2);
    st(BIT_FAULT, 1'b0);
    drive_ready_in <= 1'b0;
    st(BIT_READY, 1'b0);
    drive_ready_in <= 1'b1;
    st(BIT_READY, 1'b1);
    st(BIT_SEEKS_IDLE, 1'b0);
    all_seeks_idle_in <= 1'b1;
    st(BIT_SEEKS_IDLE, 1'b1);
    st(BIT_SEEK_DONE, 1'b1, PORT_SECONDARY);
    rd(PORT_SEEK_ACK, v);
    st(BIT_SEEK_DONE, 1'b0, PORT_SECONDARY);
    rd(PORT_STATUS, v);
    pulse(1);
    st(BIT_INDEX, ~v[BIT_INDEX]);
  endtask : t_pins
  // Silent drive: eighth revolution ends it
  task automatic t_timeout();
    mute <= 1'b1;
    wr(PORT_COMMAND, CMD_READ);
    pulse(7);
    st(BIT_IDLE, 1'b0);
    pulse(1);
    st(BIT_TIMEOUT, 1'b1);
    st(BIT_IDLE, 1'b1);
    st(BIT_XFER_DONE, 1'b1);
    st(BIT_CRC_FAIL, 1'b1, PORT_SECONDARY);
    mute <= 1'b0;
    wr(PORT_COMMAND, CMD_NOP);
    st(BIT_XFER_DONE, 1'b0);
    st(BIT_CRC_FAIL, 1'b1, PORT_SECONDARY);
  endtask : t_timeout
  task automatic t_write();
    for (int k = 0; k < SECTOR_BYTES; k++)
      wr(PORT_DATA, 8'(k) ^ 8'h3c);
    st(BIT_READY, 1'b1);
    wr(PORT_COMMAND, CMD_WRITE);
    st(BIT_IDLE, 1'b0);
    wait_idle();
    write_fault_n_in <= 1'b1;
    st(BIT_FAULT, 1'b1);
    st(BIT_CRC_FAIL, 1'b0, PORT_SECONDARY);
    chk(wr_bits, 16'(TOTAL_BITS));
    chk(wr_rem, 16'h0000);
    chk(wr_head, 8'h3c);
  endtask : t_write
  task automatic t_read();
    logic [7:0] v;
    bad_crc <= 1'b1;
    wr(PORT_COMMAND, CMD_READ);
    wait_idle();
    st(BIT_CRC_FAIL, 1'b1, PORT_SECONDARY);
    for (int k = 0; k < SECTOR_BYTES; k++) begin
      rd(PORT_DATA, v);
      chk(v, 8'(k) ^ 8'h5a);
    end
  endtask : t_read
  task automatic conclude();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_pins();
    t_timeout();
    t_write();
    t_read();
    conclude();
  end
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule : disk_sector_transfer_status_tb
